// ==== core/occ_consts.vh ====
// Purpose: Constants for the output compare channel
// Assumes: Avalon-MM word addressing, 32-bit data
// Notes: Offsets are word indices
`ifndef OCC_CONSTS_VH
`define OCC_CONSTS_VH
`define OCC_ADDR_CTRL 3'h0
`define OCC_ADDR_PRI 3'h1
`define OCC_ADDR_SEC 3'h2
`define OCC_ADDR_STAT 3'h3
`define OCC_ADDR_MASK 3'h4
`define OCC_BIT_ON 15
`define OCC_BIT_STOP_IN_IDLE 13
`define OCC_BIT_WIDE 5
`define OCC_BIT_FLT 4
`define OCC_BIT_TSEL 3
`define OCC_MODE_MSB 2
`define OCC_NARROW_MSB 15
`define OCC_CTRL_WMASK 32'h0000_A02F
`define OCC_MODE_OFF 3'h0
`define OCC_MODE_HIGH 3'h1
`define OCC_MODE_LOW 3'h2
`define OCC_MODE_TOG 3'h3
`define OCC_MODE_ONE 3'h4
`define OCC_MODE_CONT 3'h5
`define OCC_MODE_PWMNF 3'h6
`define OCC_MODE_PWMF 3'h7
`define OCC_EV_MATCH 0
`define OCC_EV_FAULT 1
`define OCC_EV_PULSE 2
`define OCC_NEV 3
`endif

// ==== core/occ_output_compare.v ====
// Purpose: One output compare channel with an Avalon-MM register slave
// Assumes: Timebases and fault input synchronous to clk_sys
// Notes: Event status bits are write-one-to-clear, set wins over clear
// Summary of operation
// - Enable bit 15 set runs the channel; clear disables it.
// - Stop-in-idle bit 13 halts the channel while the processor idles.
// - Wide bit 5 picks 32-bit compare; clear compares low 16 bits.
// - Fault status bit 4 is set by hardware; software writes ignored.
// - Fault status reads zero unless mode is 111.
// - Timebase select bit 3: one picks timebase B, zero timebase A.
// - Mode 111 PWM honouring fault; mode 110 PWM ignoring fault.
// - Mode 101 starts low, then produces continuous pulses.
// - Mode 100 starts low, then produces exactly one pulse.
// - Mode 011 toggles the output on every compare event.
// - Mode 010 starts high, drives low on compare.
// - Mode 001 starts low, drives high on compare.
// - Mode 000 leaves compare inactive, no output action.
// - Control bits 31-16, 14, 12-6 read zero, writes ignored.
`timescale 1ns/1ps
`include "occ_consts.vh"

module occ_output_compare #(
  parameter CNT_W = 32
) (
  input wire clk_sys,
  input wire resetn,
  input wire [2:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  output reg [31:0] avsReadData,
  output reg avsWaitRequest,
  input wire [CNT_W-1:0] timebaseA,
  input wire [CNT_W-1:0] timebaseB,
  input wire cpuIdle,
  input wire faultIn,
  output reg compareOutputPin,
  output reg irq
);

  // Control and compare registers
  // Control word holds only the writable bits, the rest stay zero
  // Compare values keep all 32 bits even in narrow mode
  // Status and mask share one layout: match, fault, pulse done
  // Fault flag lives apart from the control word, hardware owns it
  // Pulse-done flag stops the single-pulse mode after one pulse
  // Previous mode and run state detect a fresh start of the channel
  reg [31:0] ctrl_ff;
  reg [31:0] priVal_ff;
  reg [31:0] secVal_ff;
  reg [`OCC_NEV-1:0] stat_ff;
  reg [`OCC_NEV-1:0] mask_ff;
  reg faultFlag_ff;
  reg pulseDone_ff;
  reg ackPend_ff;
  reg [2:0] prevMode_ff;
  reg prevRun_ff;
  reg [`OCC_NEV-1:0] nxt_stat;
  reg nxt_pin;
  reg nxt_faultFlag;
  reg nxt_pulseDone;
  reg [`OCC_NEV-1:0] events;
  reg [31:0] nxt_readData;

  wire [2:0] mode;
  wire chanOn;
  wire running;
  wire modeInit;
  reg [31:0] countSel;
  wire priMatch;
  wire secMatch;
  wire busAcc;
  wire wrStrobe;

  // Compare at 16 or 32 bits, shared by both compare values
  // Narrow mode ignores the upper half of both operands
  // Upper compare bits written in narrow mode stay unused
  function cmpEq;
    input [31:0] cnt;
    input [31:0] val;
    input wide;
    begin
      if (wide) begin
        cmpEq = (cnt == val);
      end else begin
        cmpEq = (cnt[`OCC_NARROW_MSB:0] == val[`OCC_NARROW_MSB:0]);
      end
    end
  endfunction

  // Mode field decoded straight from the control word
  assign mode = ctrl_ff[`OCC_MODE_MSB:0];
  assign chanOn = ctrl_ff[`OCC_BIT_ON];
  // Idle stop freezes everything downstream, output holds its level
  assign running = chanOn & ~(ctrl_ff[`OCC_BIT_STOP_IN_IDLE] & cpuIdle);
  // Fresh mode or fresh start applies the initial pin level
  // A mode change while running restarts the chosen mode cleanly
  // Resuming from idle keeps the level, see the history update below
  assign modeInit = running & (~prevRun_ff | (prevMode_ff != mode));
  // Narrower timebase ports are zero-extended
  // Upper bits stay zero so narrow counters never match wide values
  always @* begin
    countSel = 32'h0000_0000;
    if (ctrl_ff[`OCC_BIT_TSEL]) begin
      countSel[CNT_W-1:0] = timebaseB;
    end else begin
      countSel[CNT_W-1:0] = timebaseA;
    end
  end
  // Matches only count while the channel runs in an active mode
  assign priMatch = running & (mode != `OCC_MODE_OFF) &
    cmpEq(countSel, priVal_ff, ctrl_ff[`OCC_BIT_WIDE]);
  assign secMatch = running & (mode != `OCC_MODE_OFF) &
    cmpEq(countSel, secVal_ff, ctrl_ff[`OCC_BIT_WIDE]);
  // One wait cycle per access keeps the slave a simple registered answer
  // Edge N takes the request, waitrequest drops for the next cycle
  // Edge N+1 is where the master sees the answer and a write lands
  // Pending flag blocks a second take of the same held request
  // Costs one cycle per access but keeps every answer registered
  assign busAcc = (avsRead | avsWrite) & ~ackPend_ff;
  assign wrStrobe = avsWrite & ackPend_ff;

  // Output pin behaviour per mode
  // Priority: disable forces low, idle stop freezes, then the mode
  // Initial levels win over a match in the same cycle
  // Pulse modes: secondary ends a pulse, primary starts one
  // Match events are raised in every active mode, for the status word
  always @* begin
    nxt_pin = compareOutputPin;
    nxt_faultFlag = faultFlag_ff;
    nxt_pulseDone = pulseDone_ff;
    events = {`OCC_NEV{1'b0}};
    if (!chanOn) begin
      nxt_pin = 1'b0;
      nxt_pulseDone = 1'b0;
    end else if (running) begin
      if (priMatch) begin
        events[`OCC_EV_MATCH] = 1'b1;
      end
      case (mode)
        `OCC_MODE_OFF: begin
          nxt_pin = compareOutputPin;
        end
        `OCC_MODE_HIGH: begin
          if (modeInit) begin
            nxt_pin = 1'b0;
          end else if (priMatch) begin
            nxt_pin = 1'b1;
          end
        end
        `OCC_MODE_LOW: begin
          if (modeInit) begin
            nxt_pin = 1'b1;
          end else if (priMatch) begin
            nxt_pin = 1'b0;
          end
        end
        `OCC_MODE_TOG: begin
          if (priMatch) begin
            nxt_pin = ~compareOutputPin;
          end
        end
        `OCC_MODE_ONE: begin
          if (modeInit) begin
            nxt_pin = 1'b0;
            nxt_pulseDone = 1'b0;
          end else if (!pulseDone_ff) begin
            if (compareOutputPin && secMatch) begin
              nxt_pin = 1'b0;
              nxt_pulseDone = 1'b1;
              events[`OCC_EV_PULSE] = 1'b1;
            end else if (!compareOutputPin && priMatch) begin
              nxt_pin = 1'b1;
            end
          end
        end
        `OCC_MODE_CONT: begin
          if (modeInit) begin
            nxt_pin = 1'b0;
          end else if (compareOutputPin && secMatch) begin
            nxt_pin = 1'b0;
            events[`OCC_EV_PULSE] = 1'b1;
          end else if (!compareOutputPin && priMatch) begin
            nxt_pin = 1'b1;
          end
        end
        `OCC_MODE_PWMNF,
        `OCC_MODE_PWMF: begin
          // Fault latches the pin low until the mode leaves 111
          // Secondary wins a tie so equal values give a flat low output
          // Fault event fires once, on entry into the latched state
          if (mode == `OCC_MODE_PWMF && (faultIn || faultFlag_ff)) begin
            nxt_pin = 1'b0;
            if (!faultFlag_ff) begin
              events[`OCC_EV_FAULT] = 1'b1;
            end
            nxt_faultFlag = 1'b1;
          end else if (secMatch) begin
            nxt_pin = 1'b0;
          end else if (priMatch) begin
            nxt_pin = 1'b1;
          end
        end
        default: begin
          nxt_pin = compareOutputPin;
        end
      endcase
    end
    // Hardware-only clear: leaving fault mode drops the flag
    // Software cannot reach the flag, its control bit is masked off
    if (mode != `OCC_MODE_PWMF) begin
      nxt_faultFlag = 1'b0;
    end
  end

  // Sticky status, set wins over write-one clear
  // Clear applies only on the edge where the write lands
  // An event in that same cycle survives, so none is lost
  always @* begin
    nxt_stat = stat_ff;
    if (wrStrobe && avsAddress == `OCC_ADDR_STAT) begin
      nxt_stat = stat_ff & ~avsWriteData[`OCC_NEV-1:0];
    end
    nxt_stat = nxt_stat | events;
  end

  // Read multiplexer, unmapped addresses read zero
  // Sampled on the taking edge, held until the next read
  // Fault bit is overlaid so it reads zero outside mode 111
  always @* begin
    nxt_readData = 32'h0000_0000;
    case (avsAddress)
      `OCC_ADDR_CTRL: begin
        nxt_readData = ctrl_ff;
        nxt_readData[`OCC_BIT_FLT] = faultFlag_ff &
          (mode == `OCC_MODE_PWMF);
      end
      `OCC_ADDR_PRI: begin
        nxt_readData = priVal_ff;
      end
      `OCC_ADDR_SEC: begin
        nxt_readData = secVal_ff;
      end
      `OCC_ADDR_STAT: begin
        nxt_readData[`OCC_NEV-1:0] = stat_ff;
      end
      `OCC_ADDR_MASK: begin
        nxt_readData[`OCC_NEV-1:0] = mask_ff;
      end
      default: begin
        nxt_readData = 32'h0000_0000;
      end
    endcase
  end

  // Register writes and bus handshake
  // Waitrequest rests high so an early request simply waits
  // Writes to status are handled with the sticky bits
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= 32'h0000_0000;
      priVal_ff <= 32'h0000_0000;
      secVal_ff <= 32'h0000_0000;
      mask_ff <= {`OCC_NEV{1'b0}};
      ackPend_ff <= 1'b0;
      avsWaitRequest <= 1'b1;
      avsReadData <= 32'h0000_0000;
    end else begin
      ackPend_ff <= busAcc;
      avsWaitRequest <= ~busAcc;
      if (busAcc && avsRead) begin
        avsReadData <= nxt_readData;
      end
      if (wrStrobe) begin
        case (avsAddress)
          `OCC_ADDR_CTRL: begin
            // Status and unimplemented bits are not writable
            ctrl_ff <= avsWriteData & `OCC_CTRL_WMASK;
          end
          `OCC_ADDR_PRI: begin
            priVal_ff <= avsWriteData;
          end
          `OCC_ADDR_SEC: begin
            secVal_ff <= avsWriteData;
          end
          `OCC_ADDR_MASK: begin
            mask_ff <= avsWriteData[`OCC_NEV-1:0];
          end
          default: begin
            mask_ff <= mask_ff;
          end
        endcase
      end
    end
  end

  // Channel state, pin and interrupt
  // Interrupt follows the next status value, same edge as status
  // Mask changes take effect one edge after the write lands
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      compareOutputPin <= 1'b0;
      faultFlag_ff <= 1'b0;
      pulseDone_ff <= 1'b0;
      prevMode_ff <= `OCC_MODE_OFF;
      prevRun_ff <= 1'b0;
      stat_ff <= {`OCC_NEV{1'b0}};
      irq <= 1'b0;
    end else begin
      compareOutputPin <= nxt_pin;
      faultFlag_ff <= nxt_faultFlag;
      pulseDone_ff <= nxt_pulseDone;
      // Idle keeps history so a resume is not a fresh init
      if (running || !chanOn) begin
        prevMode_ff <= mode;
        prevRun_ff <= running;
      end
      stat_ff <= nxt_stat;
      irq <= |(nxt_stat & mask_ff);
    end
  end

endmodule // occ_output_compare

// ==== verification/occ_output_compare_test.sv ====
// Purpose: Self-checking bench for the compare channel
// Assumes: Partner counts start at zero and all ones
// Notes: Pin judged after a 60-cycle run per mode
`timescale 1ns/1ps
`include "occ_consts.vh"
module occ_output_compare_test;
  reg clk_sys = 1'b0;
  reg resetn = 1'b0;
  reg [2:0] avsAddress = 3'h0;
  reg avsRead = 1'b0;
  reg avsWrite = 1'b0;
  reg [31:0] avsWriteData = 32'h0;
  reg cpuIdle = 1'b0;
  reg faultReq = 1'b0;
  reg [31:0] seed = 32'h8D55;
  reg [31:0] rd;
  wire [31:0] avsReadData, timebaseA, timebaseB;
  wire avsWaitRequest, faultIn, compareOutputPin, irq;
  integer num_errors = 0;
  integer checks = 0;
  integer i;
  integer mdl [0:7];
  // 125 MHz
  always #4 clk_sys = ~clk_sys;
  occ_output_compare u_occ_output_compare (.clk_sys(clk_sys),
    .resetn(resetn), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .timebaseA(timebaseA), .timebaseB(timebaseB), .cpuIdle(cpuIdle),
    .faultIn(faultIn), .compareOutputPin(compareOutputPin), .irq(irq));
  occ_partner u_occ_partner (.clk_sys(clk_sys), .resetn(resetn),
    .faultReq(faultReq), .timebaseA(timebaseA), .timebaseB(timebaseB),
    .faultIn(faultIn));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [8*4-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // One access; idle edge first so strobes never flip twice at once
  task bus(input w, input [2:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk_sys);
      avsAddress <= a;
      avsWrite <= w;
      avsRead <= !w;
      avsWriteData <= d;
      do begin
        @(posedge clk_sys);
        n = n + 1;
      end while (avsWaitRequest !== 1'b0 && n < 40);
      rd = avsReadData;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      if (w && a < 3'h5 && a != `OCC_ADDR_STAT)
        mdl[a] = a == `OCC_ADDR_CTRL ? d & `OCC_CTRL_WMASK : d;
      if (!w)
        chk("reg", mdl[a], rd);
      if (n == 40)
        chk("ack", 0, 1);
    end
  endtask
  // Primary set 40 counts ahead, secondary 10 counts beyond it, random upper half
  task run(input [31:0] c, input e, input [2:0] es);
    reg [31:0] b;
    begin
      bus(1, `OCC_ADDR_CTRL, 32'h0);
      @(posedge clk_sys);
      bus(1, `OCC_ADDR_STAT, 32'h7);
      seed = xs(seed);
      b = c[3] ? timebaseB - 32'd40 : timebaseA + 32'd40;
      b = {seed[31:16] | 16'h0100, b[15:0]};
      bus(1, `OCC_ADDR_PRI, b);
      bus(1, `OCC_ADDR_SEC, c[3] ? b - 32'hA : b + 32'hA);
      bus(1, `OCC_ADDR_CTRL, c | 32'hFFFF_5FD0);
      repeat (60) @(posedge clk_sys);
      mdl[0][4] = faultIn && c[2:0] == 3'h7;
      bus(0, `OCC_ADDR_CTRL, 32'h0);
      chk("pin", {31'h0, e}, {31'h0, compareOutputPin});
      mdl[3] = es;
      bus(0, `OCC_ADDR_STAT, 32'h0);
    end
  endtask
  task close_out;
    begin
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #100000;
    chk("time", 0, 1);
    close_out;
  end
  initial begin
    for (i = 0; i < 8; i = i + 1)
      mdl[i] = 0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    bus(1, 3'h7, 32'hFFFF_FFFF);
    for (i = 0; i < 8; i = i + 1)
      bus(0, i[2:0], 32'h0);
    run(32'h8001, 1'b1, 3'h1);
    mdl[3] = 1;
    bus(0, `OCC_ADDR_STAT, 32'h0);
    chk("irq", 0, {31'h0, irq});
    bus(1, `OCC_ADDR_MASK, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("irq", 1, {31'h0, irq});
    bus(1, `OCC_ADDR_STAT, 32'h7);
    repeat (2) @(posedge clk_sys);
    chk("irq", 0, {31'h0, irq});
    run(32'h8021, 1'b0, 3'h0);
    run(32'h8002, 1'b0, 3'h1);
    run(32'h8009, 1'b1, 3'h1);
    run(32'h8003, 1'b1, 3'h1);
    run(32'h0003, 1'b0, 3'h0);
    run(32'h8000, 1'b0, 3'h0);
    run(32'h8004, 1'b0, 3'h5);
    run(32'h8005, 1'b0, 3'h5);
    run(32'h8006, 1'b0, 3'h1);
    cpuIdle <= 1'b1;
    run(32'hA003, 1'b0, 3'h0);
    cpuIdle <= 1'b0;
    faultReq <= 1'b1;
    run(32'h8007, 1'b0, 3'h3);
    faultReq <= 1'b0;
    run(32'h8006, 1'b0, 3'h1);
    close_out;
  end
endmodule // occ_output_compare_test

// ==== verification/occ_partner.sv ====
// Purpose: Timer sources and fault line for the channel
// Assumes: One clock
// Notes: B counts down so a wrong source never matches
`timescale 1ns/1ps
module occ_partner (
  input wire clk_sys,
  input wire resetn,
  input wire faultReq,
  output reg [31:0] timebaseA,
  output reg [31:0] timebaseB,
  output reg faultIn
);
  // Free counts and a registered fault request
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      timebaseA <= 32'h0;
      timebaseB <= 32'hFFFF_FFFF;
      faultIn <= 1'b0;
    end else begin
      timebaseA <= timebaseA + 32'h1;
      timebaseB <= timebaseB - 32'h1;
      faultIn <= faultReq;
    end
  end
endmodule // occ_partner

// ==== verification/occ_properties.sv ====
// Purpose: Port checker for the compare channel
// Assumes: CNT_W of 32; words shadowed from acked writes
// Notes: Mode edges are skipped where init and match race
`timescale 1ns/1ps
`include "occ_consts.vh"
module occ_properties #(
  parameter CNT_W = 32
) (
  input wire clk_sys,
  input wire resetn,
  input wire [2:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  input wire [31:0] avsReadData,
  input wire avsWaitRequest,
  input wire [CNT_W-1:0] timebaseA,
  input wire [CNT_W-1:0] timebaseB,
  input wire cpuIdle,
  input wire faultIn,
  input wire compareOutputPin,
  input wire irq
);
  reg [31:0] c_ff, p_ff, s_ff;
  wire [2:0] m = c_ff[2:0];
  wire [31:0] cnt = 32'(c_ff[3] ? timebaseB : timebaseA);
  wire [31:0] wm = c_ff[5] ? 32'hFFFF_FFFF : 32'h0000_FFFF;
  wire hp = ((cnt ^ p_ff) & wm) == 32'h0;
  wire hs = ((cnt ^ s_ff) & wm) == 32'h0;
  wire go = c_ff[15] && !(c_ff[13] && cpuIdle);
  // Shadows move on the same edge as the design's registers
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      c_ff <= 32'h0;
      p_ff <= 32'h0;
      s_ff <= 32'h0;
    end else if (avsWrite && !avsWaitRequest) begin
      if (avsAddress == `OCC_ADDR_CTRL)
        c_ff <= avsWriteData & `OCC_CTRL_WMASK;
      if (avsAddress == `OCC_ADDR_PRI)
        p_ff <= avsWriteData;
      if (avsAddress == `OCC_ADDR_SEC)
        s_ff <= avsWriteData;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  property p_off;
    !c_ff[15] && !$past(c_ff[15]) |-> !compareOutputPin;
  endproperty
  a_off: assert property (p_off) else $error("pin on");
  property p_idle;
    c_ff[15] && c_ff[13] && cpuIdle |=> $stable(compareOutputPin);
  endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_tog;
    go && m == 3'h3 && hp && $stable(c_ff)
      |=> compareOutputPin != $past(compareOutputPin);
  endproperty
  a_tog: assert property (p_tog) else $error("tog");
  property p_init;
    $changed(c_ff) && go && !hp && !hs && m != 3'h0 && m != 3'h3 && !m[1]
      || $changed(c_ff) && go && !hp && !hs && m == 3'h2
      |=> compareOutputPin == ($past(m) == 3'h2);
  endproperty
  a_init: assert property (p_init) else $error("init");
  property p_set;
    go && (m == 3'h1 || m == 3'h2) && hp && $stable(c_ff)
      |=> compareOutputPin == ($past(m) == 3'h1);
  endproperty
  a_set: assert property (p_set) else $error("set");
  property p_plo;
    go && m[2] && hs && $stable(c_ff) |=> !compareOutputPin;
  endproperty
  a_plo: assert property (p_plo) else $error("plo");
  property p_phi;
    go && (m == 3'h5 || m == 3'h6) && hp && !hs && $stable(c_ff)
      |=> compareOutputPin;
  endproperty
  a_phi: assert property (p_phi) else $error("phi");
  property p_flt;
    go && m == 3'h7 && faultIn && $stable(c_ff) |=> !compareOutputPin;
  endproperty
  a_flt: assert property (p_flt) else $error("flt");
endmodule // occ_properties
bind occ_output_compare occ_properties #(.CNT_W(CNT_W)) u_occ_properties (
  .clk_sys(clk_sys), .resetn(resetn), .avsAddress(avsAddress),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
  .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
  .timebaseA(timebaseA), .timebaseB(timebaseB), .cpuIdle(cpuIdle),
  .faultIn(faultIn), .compareOutputPin(compareOutputPin), .irq(irq));
